// File: rtl/isr_det_sync.sv
// Detection status capture with change events for the input status readback block.
`timescale 1ns/1ps
module isr_det_sync
    import isr_pkg::*;
#(
    parameter int N = ISR_DET_BITS
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         reset,
    // Live decoder state.
    input  wire logic [N-1:0] det_in,
    // Registered state and change pulses.
    output logic      [N-1:0] det_out,
    output logic      [N-1:0] det_change
);
    typedef struct packed {
        logic [N-1:0] det;
        logic [N-1:0] chg;
    } isr_ds_state_t;

    isr_ds_state_t st_reg;
    isr_ds_state_t st_next;

    always_comb begin
        st_next     = st_reg;
        st_next.det = det_in;
        st_next.chg = det_in ^ st_reg.det;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign det_out    = st_reg.det;
    assign det_change = st_reg.chg;
endmodule

// File: rtl/isr_pkg.sv
// Package with register map, field layout and reset values of the input status readback block.
package isr_pkg;
    localparam int          ISR_ADDR_W          = 8;
    localparam int          ISR_DATA_W          = 8;
    // Register addresses as printed; the bus is byte wide, so no word scaling applies.
    localparam logic [7:0]  ISR_ADDR_CS_FIRST   = 8'h0E;
    localparam logic [7:0]  ISR_ADDR_CS_LAST    = 8'h17;
    localparam logic [7:0]  ISR_ADDR_RSV_FIRST  = 8'h5E;
    localparam logic [7:0]  ISR_ADDR_RSV_LAST   = 8'h63;
    localparam logic [7:0]  ISR_ADDR_DETECT     = 8'h64;
    localparam logic [7:0]  ISR_ADDR_SCALE_LO   = 8'h71;
    localparam logic [7:0]  ISR_ADDR_SCALE_MID  = 8'h72;
    localparam logic [7:0]  ISR_ADDR_SCALE_HI   = 8'h73;
    localparam logic [7:0]  ISR_ADDR_IRQ_STATUS = 8'h78;
    localparam logic [7:0]  ISR_ADDR_IRQ_MASK   = 8'h79;
    // Channel-status byte numbers of the trailing professional fields.
    localparam int          ISR_CS_SAMPLE_ADDR  = 14;
    localparam int          ISR_CS_TIME_OF_DAY  = 18;
    localparam int          ISR_CS_RELIABILITY  = 22;
    localparam int          ISR_CS_CHECK_BYTE   = 23;
    localparam int          ISR_CS_BYTES        = 10;
    // Detection register fields.
    localparam int          ISR_BIT_DSD         = 0;
    localparam int          ISR_BIT_I2S         = 1;
    localparam int          ISR_BIT_SPDIF       = 2;
    localparam int          ISR_BIT_DOP         = 3;
    localparam int          ISR_DET_BITS        = 4;
    localparam logic [3:0]  ISR_DET_RESERVED    = 4'h0;
    localparam logic [3:0]  ISR_DET_RESET       = 4'h0;
    localparam logic [23:0] ISR_SCALE_RESET     = 24'h000000;
    localparam logic [7:0]  ISR_CHECK_NONE      = 8'h00;
    localparam logic [7:0]  ISR_BYTE_RESET      = 8'h00;
endpackage

// File: rtl/isr_readback.sv
// Top of the input status readback block: register bank, channel-status capture, interrupt.
// Functional notes
// - Channel-status bytes 14-17 give sample count of block's first sample.
// - Bytes 18-21 give source encoding time in samples since midnight.
// - Byte 22 reliability flags; zero means reliable, one unreliable.
// - Byte 23 is check byte; zero means no check code implemented.
// - Detection bit 3 shows DSD-over-PCM stream detected on I2S or S/PDIF.
// - Detection bit 2 shows S/PDIF receiver decoding valid frames.
// - Detection bit 1 shows valid I2S word and bit clock arrangement.
// - Detection bit 0 shows DSD fallback in use after both decoders failed.
// - Detection register at 100 is read-only, upper bits zero, resets zero.
// - Addresses 94-99 are reserved read-only and ignore writes.
// - 24-bit feedback scale at 113-115 is read-only, resets zero.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module isr_readback
    import isr_pkg::*;
(
    // Clock and reset.
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    // Register port.
    input  wire logic [ISR_ADDR_W-1:0] reg_addr,
    input  wire logic [ISR_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [ISR_DATA_W-1:0] reg_rdata,
    // Decoder state.
    input  wire logic                  dsd_over_pcm_detected,
    input  wire logic                  spdif_frames_valid,
    input  wire logic                  i2s_clocks_valid,
    input  wire logic                  dsd_fallback_active,
    // Channel-status bytes from the S/PDIF receiver.
    input  wire logic                  cs_byte_valid,
    input  wire logic [4:0]            cs_byte_index,
    input  wire logic [7:0]            cs_byte_data,
    input  wire logic                  cs_block_end,
    // Feedback scale from the second ADC path.
    input  wire logic [23:0]           second_adc_feedback_scale,
    // Interrupt.
    output logic                       irq
);
    localparam int NEV = ISR_DET_BITS + 1;

    // Every check in this module runs on the core clock and rests while reset is high.
    // Checks that look one cycle back also test reset in their antecedent, because
    // the attempt begun at the releasing edge would otherwise compare against stale state.
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);

    typedef struct packed {
        logic [ISR_CS_BYTES-1:0][7:0] cs_shadow;
        logic [ISR_CS_BYTES-1:0][7:0] cs_live;
        logic [23:0]                  scale;
        logic [NEV-1:0]               irq_status;
        logic [NEV-1:0]               irq_mask;
        logic [ISR_DATA_W-1:0]        rdata;
        logic                         irq;
    } isr_state_t;

    isr_state_t       st_reg;
    isr_state_t       st_next;
    logic [3:0]       det_now;
    logic [3:0]       det_q;
    logic [3:0]       det_chg;
    logic [NEV-1:0]   ev;
    logic [4:0]       cs_slot;

    // The decoders are sampled every cycle, so a read sees the state registered in u_det one cycle earlier.
    assign det_now[ISR_BIT_DOP]   = dsd_over_pcm_detected;
    assign det_now[ISR_BIT_SPDIF] = spdif_frames_valid;
    assign det_now[ISR_BIT_I2S]   = i2s_clocks_valid;
    // Fallback is only believed while neither PCM path is decoding.
    assign det_now[ISR_BIT_DSD]   = dsd_fallback_active
                                    & ~spdif_frames_valid
                                    & ~i2s_clocks_valid;

    isr_det_sync #(
        .N (ISR_DET_BITS)
    ) u_det (
        .core_clk   (core_clk),
        .reset      (reset),
        .det_in     (det_now),
        .det_out    (det_q),
        .det_change (det_chg)
    );

    assign ev      = {cs_block_end, det_chg};
    assign cs_slot = cs_byte_index - 5'(ISR_CS_SAMPLE_ADDR);

    always_comb begin
        st_next = st_reg;
        // Bytes are gathered into a live copy and published whole at block end, so a read
        // never mixes fields of two blocks.
        if (cs_byte_valid && cs_byte_index >= 5'(ISR_CS_SAMPLE_ADDR)
            && cs_byte_index <= 5'(ISR_CS_CHECK_BYTE)) begin
            st_next.cs_live[cs_slot[3:0]] = cs_byte_data;
        end
        if (cs_block_end) begin
            st_next.cs_shadow = st_next.cs_live;
        end
        st_next.scale = second_adc_feedback_scale;
        if (reg_write && reg_addr == ISR_ADDR_IRQ_MASK) begin
            st_next.irq_mask = reg_wdata[NEV-1:0];
        end
        // A set arriving with a clear wins.
        if (reg_write && reg_addr == ISR_ADDR_IRQ_STATUS) begin
            st_next.irq_status = st_reg.irq_status & ~reg_wdata[NEV-1:0];
        end
        st_next.irq_status = st_next.irq_status | ev;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);
        // Writes to every other address, reserved ones included, are dropped.
        st_next.rdata = ISR_BYTE_RESET;
        if (reg_read) begin
            if (reg_addr >= ISR_ADDR_CS_FIRST && reg_addr <= ISR_ADDR_CS_LAST) begin
                st_next.rdata = st_reg.cs_shadow[4'(reg_addr - ISR_ADDR_CS_FIRST)];
            end else begin
                unique case (reg_addr)
                    ISR_ADDR_DETECT: begin
                        st_next.rdata = {ISR_DET_RESERVED, det_q};
                    end
                    ISR_ADDR_SCALE_LO: begin
                        st_next.rdata = st_reg.scale[7:0];
                    end
                    ISR_ADDR_SCALE_MID: begin
                        st_next.rdata = st_reg.scale[15:8];
                    end
                    ISR_ADDR_SCALE_HI: begin
                        st_next.rdata = st_reg.scale[23:16];
                    end
                    ISR_ADDR_IRQ_STATUS: begin
                        st_next.rdata = {3'h0, st_reg.irq_status};
                    end
                    ISR_ADDR_IRQ_MASK: begin
                        st_next.rdata = {3'h0, st_reg.irq_mask};
                    end
                    default: begin
                        st_next.rdata = ISR_BYTE_RESET;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign irq       = st_reg.irq;

    // Detection register readback and tracking of the live decoder state.
    AST_DET_READ: assert property (
        !reset && reg_read && reg_addr == ISR_ADDR_DETECT
        |=> reg_rdata == {4'h0, $past(det_q)})
        else $error("Detection read mismatch.");
    AST_DET_UPPER: assert property (
        reg_read && reg_addr == ISR_ADDR_DETECT
        |=> reg_rdata[7:4] == ISR_DET_RESERVED)
        else $error("Reserved detection bits read nonzero.");
    AST_DET_WRITE_IGNORED: assert property (
        !reset && reg_write && reg_addr == ISR_ADDR_DETECT
        |=> det_q == $past(det_now))
        else $error("Write to the detection register took effect.");
    AST_DOP_TRACK: assert property (
        !reset
        |=> det_q[ISR_BIT_DOP] == $past(dsd_over_pcm_detected))
        else $error("DSD-over-PCM bit does not track detector.");
    AST_SPDIF_TRACK: assert property (
        !reset
        |=> det_q[ISR_BIT_SPDIF] == $past(spdif_frames_valid))
        else $error("S/PDIF bit does not track receiver.");
    AST_I2S_TRACK: assert property (
        !reset
        |=> det_q[ISR_BIT_I2S] == $past(i2s_clocks_valid))
        else $error("I2S bit does not track clock detector.");
    AST_DSD_EXCL: assert property (
        det_q[ISR_BIT_DSD]
        |-> !det_q[ISR_BIT_I2S] && !det_q[ISR_BIT_SPDIF])
        else $error("DSD fallback shown while a PCM path decodes.");
    AST_DSD_FALLBACK: assert property (
        !reset && dsd_fallback_active && !spdif_frames_valid && !i2s_clocks_valid
        |=> det_q[ISR_BIT_DSD])
        else $error("DSD fallback not shown while both PCM paths fail.");
    AST_DSD_IDLE: assert property (
        !reset && !dsd_fallback_active
        |=> !det_q[ISR_BIT_DSD])
        else $error("DSD bit set while the fallback is unused.");
    // Change pulses feed the interrupt status; each is the difference of two samples.
    AST_DET_CHANGE: assert property (
        !reset
        |=> det_chg == (det_q ^ $past(det_q)))
        else $error("Detection change pulse mismatch.");

    // Reset state: nothing readable is left over from before reset.
    AST_RESET_RDATA: assert property (
        $past(reset)
        |-> reg_rdata == 8'h00 && !irq)
        else $error("Read data or interrupt not clear after reset.");
    AST_RESET_DET: assert property (
        $past(reset)
        |-> det_q == ISR_DET_RESET)
        else $error("Detection bits not clear after reset.");
    AST_RESET_SCALE: assert property (
        $past(reset)
        |-> st_reg.scale == ISR_SCALE_RESET)
        else $error("Scale copy not clear after reset.");

    // Reserved and unmapped addresses.
    AST_RSV_ZERO: assert property (
        reg_read && reg_addr >= ISR_ADDR_RSV_FIRST && reg_addr <= ISR_ADDR_RSV_LAST
        |=> reg_rdata == 8'h00)
        else $error("Reserved address reads nonzero.");
    AST_RSV_WRITE: assert property (
        !reset && reg_write && reg_addr >= ISR_ADDR_RSV_FIRST && reg_addr <= ISR_ADDR_RSV_LAST
        |=> st_reg.irq_mask == $past(st_reg.irq_mask))
        else $error("Reserved write changed the interrupt mask.");
    AST_UNMAPPED_ZERO: assert property (
        reg_read && reg_addr > ISR_ADDR_CS_LAST && reg_addr < ISR_ADDR_RSV_FIRST
        |=> reg_rdata == 8'h00)
        else $error("Unmapped address reads nonzero.");

    // Feedback scale: byte lanes, two samples of lag, writes dropped.
    AST_SCALE_LO: assert property (
        !reset && !$past(reset) && reg_read && reg_addr == ISR_ADDR_SCALE_LO
        |=> reg_rdata == $past(second_adc_feedback_scale[7:0], 2))
        else $error("Scale low byte mismatch.");
    AST_SCALE_MID: assert property (
        !reset && !$past(reset) && reg_read && reg_addr == ISR_ADDR_SCALE_MID
        |=> reg_rdata == $past(second_adc_feedback_scale[15:8], 2))
        else $error("Scale middle byte mismatch.");
    AST_SCALE_HI: assert property (
        !reset && !$past(reset) && reg_read && reg_addr == ISR_ADDR_SCALE_HI
        |=> reg_rdata == $past(second_adc_feedback_scale[23:16], 2))
        else $error("Scale high byte mismatch.");
    AST_SCALE_WR_IGNORED: assert property (
        !reset && reg_write
        |=> st_reg.scale == $past(second_adc_feedback_scale))
        else $error("A write disturbed the scale copy.");

    // Every stored channel-status slot takes its byte one cycle after the strobe.
    for (genvar i = 0; i < ISR_CS_BYTES; i++) begin : g_cs_chk
        AST_CS_CAPTURE: assert property (
            !reset && cs_byte_valid && cs_byte_index == 5'(ISR_CS_SAMPLE_ADDR + i)
            |=> st_reg.cs_live[i] == $past(cs_byte_data))
            else $error("Channel-status byte not captured.");
    end
    AST_CS_EARLY_DROPPED: assert property (
        !reset && cs_byte_valid && cs_byte_index < 5'(ISR_CS_SAMPLE_ADDR)
        |=> $stable(st_reg.cs_live))
        else $error("An earlier channel-status byte was stored.");
    AST_CS_CHECK: assert property (
        !reset && cs_byte_valid && cs_byte_index == 5'(ISR_CS_CHECK_BYTE) && cs_block_end
        |=> st_reg.cs_shadow[ISR_CS_CHECK_BYTE - ISR_CS_SAMPLE_ADDR] == $past(cs_byte_data))
        else $error("Check byte not published.");
    AST_CS_HOLD: assert property (
        !reset && !cs_block_end
        |=> $stable(st_reg.cs_shadow))
        else $error("Published channel-status bytes changed between blocks.");
    AST_CS_READ: assert property (
        !reset && reg_read && reg_addr >= ISR_ADDR_CS_FIRST && reg_addr <= ISR_ADDR_CS_LAST
        |=> reg_rdata == $past(st_reg.cs_shadow[4'(reg_addr - ISR_ADDR_CS_FIRST)]))
        else $error("Channel-status read mismatch.");

    // Interrupt bookkeeping: write one to clear, a set in the same cycle wins.
    AST_IRQ_SET_WINS: assert property (
        !reset && (|ev)
        |=> (st_reg.irq_status & $past(ev)) == $past(ev))
        else $error("Interrupt event lost.");
    AST_IRQ_CLEAR: assert property (
        !reset && reg_write && reg_addr == ISR_ADDR_IRQ_STATUS && ev == '0
        |=> (st_reg.irq_status & $past(reg_wdata[NEV-1:0])) == '0)
        else $error("Status bit not cleared by writing one.");
    AST_IRQ_HOLD: assert property (
        !reset && !reg_write && ev == '0
        |=> $stable(st_reg.irq_status))
        else $error("Status changed without event or write.");
    AST_MASK_WRITE: assert property (
        !reset && reg_write && reg_addr == ISR_ADDR_IRQ_MASK
        |=> st_reg.irq_mask == $past(reg_wdata[NEV-1:0]))
        else $error("Mask write not taken.");
    AST_STATUS_READ: assert property (
        !reset && reg_read && reg_addr == ISR_ADDR_IRQ_STATUS
        |=> reg_rdata == {3'h0, $past(st_reg.irq_status)})
        else $error("Status read mismatch.");
    AST_MASK_READ: assert property (
        !reset && reg_read && reg_addr == ISR_ADDR_IRQ_MASK
        |=> reg_rdata == {3'h0, $past(st_reg.irq_mask)})
        else $error("Mask read mismatch.");
    AST_IRQ_LEVEL: assert property (
        irq == |(st_reg.irq_status & st_reg.irq_mask))
        else $error("Interrupt level disagrees with status and mask.");
    AST_NO_READ_ZERO: assert property (
        !reg_read
        |=> reg_rdata == 8'h00)
        else $error("Read data present without read.");

    COV_DOP: cover property ($rose(det_q[ISR_BIT_DOP]));
    COV_FALLBACK: cover property ($rose(det_q[ISR_BIT_DSD]));
    COV_IRQ: cover property ($rose(irq));
    COV_BLOCK_READ: cover property (
        cs_block_end ##[1:40] (reg_read && reg_addr == ISR_ADDR_CS_LAST));
    COV_SCALE_READ: cover property (
        (reg_read && reg_addr == ISR_ADDR_SCALE_HI) ##1 (reg_rdata != 8'h00));
endmodule

// File: verification/isr_readback_tb.sv
// Self-checking testbench of the input status readback block.
`timescale 1ns/1ps
module isr_readback_tb;
    import isr_pkg::*;
    logic        core_clk  = 1'b0;
    logic        reset     = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic        send      = 1'b0;
    logic [3:0]  levels    = 4'h0;
    logic [79:0] block     = '0;
    logic [23:0] scale     = 24'h000000;
    logic [7:0]  reg_rdata;
    logic        irq, busy, dop, spv, i2v, dsf, csv, cse;
    logic [4:0]  csi;
    logic [7:0]  csd;
    int          failures    = 0;
    int          check_count = 0;

    isr_readback dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .dsd_over_pcm_detected(dop), .spdif_frames_valid(spv),
        .i2s_clocks_valid(i2v), .dsd_fallback_active(dsf), .cs_byte_valid(csv),
        .cs_byte_index(csi), .cs_byte_data(csd), .cs_block_end(cse),
        .second_adc_feedback_scale(scale), .irq(irq));
    isr_source_model src (.core_clk(core_clk), .send(send), .levels(levels), .block(block),
        .dsd_over_pcm_detected(dop), .spdif_frames_valid(spv), .i2s_clocks_valid(i2v),
        .dsd_fallback_active(dsf), .cs_byte_valid(csv), .cs_byte_index(csi),
        .cs_byte_data(csd), .cs_block_end(cse), .busy(busy));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("Checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask

    task automatic send_block();
        @(posedge core_clk);
        send <= 1'b1;
        @(posedge core_clk);
        send <= 1'b0;
        #1;
        for (int t = 0; busy && t < 40; t++) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    // The fallback bit must drop whenever either PCM decoder is valid.
    function automatic logic [7:0] det_exp(input logic [3:0] l);
        return {4'h0, l[3], l[2], l[1], l[0] & ~(l[2] | l[1])};
    endfunction

    initial begin
        logic [79:0] v;
        void'($urandom(32'h2757));
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rd(ISR_ADDR_DETECT, 8'h00, "detect reset");
        rd(ISR_ADDR_SCALE_HI, 8'h00, "scale reset");
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk);
            levels <= (i < 16) ? 4'(i) : 4'($urandom);
            wr(ISR_ADDR_DETECT, 8'hFF);
            rd(ISR_ADDR_DETECT, det_exp(levels), "detect");
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            scale <= (i == 0) ? 24'hFFFFFF : 24'($urandom);
            wr(ISR_ADDR_SCALE_LO, 8'h5A);
            rd(ISR_ADDR_SCALE_LO, scale[7:0], "scale lo");
            rd(ISR_ADDR_SCALE_MID, scale[15:8], "scale mid");
            rd(ISR_ADDR_SCALE_HI, scale[23:16], "scale hi");
        end
        for (int a = ISR_ADDR_RSV_FIRST; a <= ISR_ADDR_RSV_LAST; a++) begin
            wr(8'(a), 8'($urandom));
            rd(8'(a), 8'h00, "reserved");
        end
        rd(8'h40, 8'h00, "unmapped");
        wr(ISR_ADDR_IRQ_MASK, 8'h00);
        wr(ISR_ADDR_IRQ_STATUS, 8'h1F);
        rd(ISR_ADDR_IRQ_STATUS, 8'h00, "status cleared");
        for (int b = 0; b < 3; b++) begin
            v = 80'({$urandom, $urandom, $urandom});
            if (b == 1) begin
                v[79:72] = ISR_CHECK_NONE;
            end
            @(posedge core_clk);
            block <= v;
            send_block();
            for (int k = 0; k < 10; k++) begin
                rd(ISR_ADDR_CS_FIRST + 8'(k), v[8*k +: 8], "cs byte");
            end
        end
        rd(ISR_ADDR_IRQ_STATUS, 8'h10, "status block end");
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(ISR_ADDR_IRQ_MASK, 8'h10);
        @(posedge core_clk);
        #1 chk("irq raised", 8'h01, {7'h00, irq});
        wr(ISR_ADDR_IRQ_STATUS, 8'h10);
        @(posedge core_clk);
        #1 chk("irq cleared", 8'h00, {7'h00, irq});
        complete_run();
    end

    // About 330 cycles are expected; the limit leaves ample margin.
    initial begin
        #20000;
        failures++;
        complete_run();
    end
endmodule

// File: verification/isr_source_model.sv
// Behavioural audio source: decoder status levels and a channel-status byte stream.
`timescale 1ns/1ps
module isr_source_model (
    // Clock.
    input  wire logic        core_clk,
    // Commands from the bench.
    input  wire logic        send,
    input  wire logic [3:0]  levels,
    input  wire logic [79:0] block,
    // Lines towards the device.
    output logic             dsd_over_pcm_detected,
    output logic             spdif_frames_valid,
    output logic             i2s_clocks_valid,
    output logic             dsd_fallback_active,
    output logic             cs_byte_valid = 1'b0,
    output logic [4:0]       cs_byte_index = 5'h00,
    output logic [7:0]       cs_byte_data  = 8'h00,
    output logic             cs_block_end  = 1'b0,
    output logic             busy
);
    int n = -1;
    assign {dsd_over_pcm_detected, spdif_frames_valid, i2s_clocks_valid,
            dsd_fallback_active} = levels;
    assign busy = (n >= 0) || cs_byte_valid;
    // Between bytes the data lines toggle, so a stale byte is never mistaken for a fresh one.
    always @(posedge core_clk) begin
        cs_byte_valid <= 1'b0;
        cs_block_end  <= 1'b0;
        cs_byte_data  <= ~cs_byte_data;
        if (n >= 0) begin
            cs_byte_valid <= 1'b1;
            cs_byte_index <= 5'(n);
            cs_byte_data  <= (n >= 14) ? block[8*(n-14) +: 8] : 8'($urandom);
            cs_block_end  <= (n == 23);
            n             <= (n == 23) ? -1 : n + 1;
        end else if (send) begin
            n <= 0;
        end
    end
endmodule
